// *** inc/mip_pkg.sv ***
// constants and types for the maskable interrupt priority sequencer
package mip_pkg;
   localparam int          LVL_W        = 3;
   localparam int          NUM_W        = 8;
   localparam int          PC_W         = 20;
   localparam int          ADDR_W       = 12;
   localparam int          LEN_W        = 5;
   localparam logic [2:0]  LVL_OFF      = 3'h0;
   localparam logic [2:0]  LVL_TOP      = 3'h7;
   // register byte addresses
   localparam logic [11:0] ADDR_FLAG    = 12'h000;
   localparam logic [11:0] ADDR_STATUS  = 12'h004;
   localparam logic [11:0] ADDR_INFO    = 12'h008;
   localparam logic [3:0]  SRC_PAGE     = 4'h1;
   // source control fields
   localparam int          SRC_REQ_BIT  = 3;
   // flag word fields
   localparam int          FLG_D_BIT    = 5;
   localparam int          FLG_I_BIT    = 6;
   localparam int          FLG_U_BIT    = 7;
   localparam int          FLG_IPL_LO   = 12;
   localparam logic [15:0] FLG_RESET    = 16'h0000;
   // entry length in cycles
   localparam logic [4:0]  LEN_BASE     = 5'h12;
   localparam logic [4:0]  LEN_BUS8     = 5'h14;
   localparam logic [4:0]  LEN_DBG_ADD  = 5'h02;
   localparam logic [4:0]  LEN_ONE_ADD  = 5'h01;
   localparam int          MAX_WAIT     = 30;
   localparam logic [2:0]  BEATS_WORD   = 3'h2;
   localparam logic [2:0]  BEATS_BYTE   = 3'h4;
   // interrupt numbers
   localparam logic [7:0]  SRC_NUM_BASE = 8'h04;
   localparam logic [7:0]  SWI_U_LO     = 8'h20;
   localparam logic [7:0]  SWI_U_HI     = 8'h3f;
   localparam logic [7:0]  NUM_NMI      = 8'hf8;
   localparam logic [7:0]  NUM_DBG      = 8'hf4;
   localparam logic [7:0]  NUM_WDT      = 8'hf0;
   localparam logic [7:0]  NUM_STEP     = 8'hec;
   localparam logic [7:0]  NUM_AMATCH   = 8'he8;

   typedef enum logic [4:0] {
      S_IDLE = 5'b00001,
      S_INFO = 5'b00010,
      S_PUSH = 5'b00100,
      S_FILL = 5'b01000,
      S_LOAD = 5'b10000
   } mip_state_t;

   typedef enum logic [2:0] {
      K_PERI = 3'h0,
      K_NMI  = 3'h1,
      K_DBG  = 3'h2,
      K_WDT  = 3'h3,
      K_STEP = 3'h4,
      K_AM   = 3'h5,
      K_SWI  = 3'h6
   } mip_kind_t;
endpackage

// *** rtl/mip_sequencer.sv ***
// interrupt control state and entry sequencer with apb register access
// Behaviour
// - global enable gates all maskable, resets 0
// - hardware sets request, clears on acceptance
// - software writes 0 clears; 1 ignored
// - three-bit level, 0 off, 7 highest
// - accept if enabled, requested, level above ipl
// - ipl 7 blocks every maskable source
// - enable, requests, levels, ipl stored independently
// - rewrite race avoided; hardware set wins
// - prioritise at instruction end, enter next cycle
// - string and accumulate ops suspend for entry
// - entry first reads info, clears request
// - copy flags, clear enable/step/stack, push
// - stack flag kept for software 32..63
// - last step loads accepted level into ipl
// - watchdog/nmi load 7, reset 0, others keep
// - 18/19/20 cycles by parity, 20 on 8-bit
// - debug break +2, step/address match +1
// - wait before entry at most thirty cycles
// - push pc top/flag word, then pc low
// - equal levels resolve by fixed hardware order
// - even sp word pushes, odd sp byte pushes
//
// The APB register port and the address map are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module mip_sequencer
   import mip_pkg::*;
#(
   parameter int NSRC = 28
)(
   input  wire logic                  pclk,
   input  wire logic                  presetn,
   input  wire logic                  psel,
   input  wire logic                  penable,
   input  wire logic                  pwrite,
   input  wire logic [mip_pkg::ADDR_W-1:0] paddr,
   input  wire logic [31:0]           pwdata,
   output logic [31:0]                prdata,
   output logic                       pready,
   output logic                       pslverr,
   input  wire logic [NSRC-1:0]       src_req,
   input  wire logic                  core_instr_done,
   input  wire logic                  core_suspendable,
   input  wire logic                  nmi_req,
   input  wire logic                  dbg_req,
   input  wire logic                  wdt_req,
   input  wire logic                  step_req,
   input  wire logic                  amatch_req,
   input  wire logic                  swi_req,
   input  wire logic [mip_pkg::NUM_W-1:0]  swi_num,
   input  wire logic [mip_pkg::PC_W-1:0]   core_pc,
   input  wire logic                  sp_odd,
   input  wire logic                  vec_odd,
   input  wire logic                  bus8,
   output logic                       core_suspend,
   output logic                       entry_start,
   output mip_pkg::mip_kind_t         entry_kind,
   output logic                       entry_busy,
   output logic                       info_rd,
   output logic [mip_pkg::NUM_W-1:0]  info_num,
   output logic [mip_pkg::LVL_W-1:0]  info_lvl,
   output logic                       stk_wr,
   output logic                       stk_byte,
   output logic [15:0]                stk_data,
   output logic                       entry_done,
   output logic [15:0]                flag_word
);
   import mip_pkg::*;

   function automatic logic src_hit(input logic [ADDR_W-1:0] a, input int i);
      src_hit = (a[11:8] == SRC_PAGE) && (a[7:2] == 6'(i));
   endfunction

   mip_state_t             state_r;
   mip_state_t             state_nxt;
   logic [15:0]            flag_r;
   logic [15:0]            flag_tmp_r;
   logic [NSRC-1:0]        req_r;
   logic [LVL_W-1:0]       lvl_r [NSRC];
   logic [NSRC-1:0]        cand;
   logic [NSRC-1:0]        src_wr;
   logic [NSRC-1:0]        src_rd;
   logic [LVL_W-1:0]       best_lvl;
   logic [5:0]             best_idx;
   logic                   best_ok;
   logic [LVL_W-1:0]       processor_priority_level;
   logic                   boundary;
   logic                   any_req;
   logic                   accept;
   mip_kind_t              kind_sel;
   logic [NUM_W-1:0]       num_sel;
   logic [LEN_W-1:0]       extra;
   logic [LEN_W-1:0]       len_sel;
   mip_kind_t              kind_r;
   logic [5:0]             idx_r;
   logic [NUM_W-1:0]       num_r;
   logic [LVL_W-1:0]       newlvl_r;
   logic                   ipl_load_r;
   logic [LEN_W-1:0]       len_r;
   logic [LEN_W-1:0]       cnt_r;
   logic                   byte_r;
   logic [2:0]             beat_r;
   logic [2:0]             nbeats;
   logic [15:0]            w1_r;
   logic [15:0]            pcl_r;
   logic                   wsel;
   logic                   hsel;
   logic [15:0]            word;
   logic [15:0]            push_data;
   logic                   keep_u;
   logic                   wr_acc;
   logic                   rd_setup;
   logic                   hit_flag;
   logic                   hit_stat;
   logic                   hit_info;
   logic                   hit_src;
   logic [31:0]            rd_mux;
   logic [31:0]            src_rd_data;
   logic [31:0]            prdata_r;
   logic                   pslverr_r;
   logic                   start_r;
   logic                   stk_wr_r;
   logic [15:0]            stk_data_r;
   logic [NUM_W-1:0]       info_num_r;
   logic [LVL_W-1:0]       info_lvl_r;

   // apb decode
   assign wr_acc   = psel & penable & pwrite;
   assign rd_setup = psel & ~penable;
   assign hit_flag = (paddr == ADDR_FLAG);
   assign hit_stat = (paddr == ADDR_STATUS);
   assign hit_info = (paddr == ADDR_INFO);
   assign hit_src  = |src_rd;

   // per-source control state
   genvar gi;
   generate
      for (gi = 0; gi < NSRC; gi++)
      begin : g_src
         assign src_rd[gi] = src_hit(paddr, gi);
         assign src_wr[gi] = wr_acc & src_rd[gi];
         // requested, above ipl; global enable applied in any_req
         assign cand[gi] = req_r[gi] && (lvl_r[gi] > processor_priority_level);
         always_ff @(posedge pclk or negedge presetn)
         begin
            if (!presetn)
            begin
               req_r[gi] <= 1'b0;
               lvl_r[gi] <= LVL_OFF;
            end
            else
            begin
               // set wins over any clear
               if (src_req[gi])
                  req_r[gi] <= 1'b1;
               else if (state_r == S_INFO && kind_r == K_PERI && idx_r == 6'(gi))
                  req_r[gi] <= 1'b0;
               else if (src_wr[gi] && !pwdata[SRC_REQ_BIT])
                  req_r[gi] <= 1'b0;
               if (src_wr[gi])
                  lvl_r[gi] <= pwdata[LVL_W-1:0];
            end
         end
      end
   endgenerate

   always_comb
   begin
      src_rd_data = 32'h0000_0000;
      for (int i = 0; i < NSRC; i++)
         if (src_rd[i])
            src_rd_data = {28'h0000000, req_r[i], lvl_r[i]};
   end

   // resolution: highest level, ties to lowest index
   always_comb
   begin
      best_lvl = LVL_OFF;
      best_idx = 6'h00;
      best_ok  = 1'b0;
      for (int i = NSRC - 1; i >= 0; i--)
         if (cand[i] && lvl_r[i] >= best_lvl)
         begin
            best_lvl = lvl_r[i];
            best_idx = 6'(i);
            best_ok  = 1'b1;
         end
   end

   assign processor_priority_level      = flag_r[FLG_IPL_LO +: LVL_W];
   // global enable gates all maskable sources
   assign any_req  = nmi_req | dbg_req | wdt_req | swi_req | step_req | amatch_req
                     | (best_ok & flag_r[FLG_I_BIT]);
   // take at instruction end or mid suspendable op
   assign boundary = core_instr_done | core_suspendable;
   assign accept   = (state_r == S_IDLE) & boundary & any_req;

   // fixed order: nmi, debug, watchdog, peripheral, step, match, software
   assign kind_sel = nmi_req ? K_NMI :
                     dbg_req ? K_DBG :
                     wdt_req ? K_WDT :
                     (best_ok & flag_r[FLG_I_BIT]) ? K_PERI :
                     step_req ? K_STEP :
                     amatch_req ? K_AM : K_SWI;

   assign num_sel = (kind_sel == K_NMI) ? NUM_NMI :
                    (kind_sel == K_DBG) ? NUM_DBG :
                    (kind_sel == K_WDT) ? NUM_WDT :
                    (kind_sel == K_PERI) ? SRC_NUM_BASE + 8'(best_idx) :
                    (kind_sel == K_STEP) ? NUM_STEP :
                    (kind_sel == K_AM) ? NUM_AMATCH : swi_num;

   // sequence length by bus and parity
   assign extra   = (kind_sel == K_DBG) ? LEN_DBG_ADD :
                    (kind_sel == K_STEP || kind_sel == K_AM) ? LEN_ONE_ADD : 5'h00;
   assign len_sel = (bus8 ? LEN_BUS8 : LEN_BASE + 5'(vec_odd) + 5'(sp_odd)) + extra;

   assign keep_u  = (kind_r == K_SWI) && (num_r >= SWI_U_LO) && (num_r <= SWI_U_HI);

   // stack push beats
   assign nbeats    = byte_r ? BEATS_BYTE : BEATS_WORD;
   assign wsel      = byte_r ? beat_r[1] : beat_r[0];
   assign hsel      = byte_r & beat_r[0];
   assign word      = wsel ? pcl_r : w1_r;
   assign push_data = hsel ? {8'h00, word[15:8]} : (byte_r ? {8'h00, word[7:0]} : word);

   always_comb
   begin
      state_nxt = state_r;
      unique case (state_r)
         S_IDLE: if (accept) state_nxt = S_INFO;
         S_INFO: state_nxt = S_PUSH;
         S_PUSH: if (beat_r == nbeats - 3'h1) state_nxt = S_FILL;
         S_FILL: if (cnt_r == len_r - 5'h02) state_nxt = S_LOAD;
         S_LOAD: state_nxt = S_IDLE;
         default: state_nxt = S_IDLE;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         state_r <= S_IDLE;
         cnt_r   <= 5'h00;
         beat_r  <= 3'h0;
      end
      else
      begin
         state_r <= state_nxt;
         cnt_r   <= (state_r == S_IDLE) ? 5'h00 : cnt_r + 5'h01;
         beat_r  <= (state_r == S_PUSH) ? beat_r + 3'h1 : 3'h0;
      end
   end

   // capture of the accepted entry
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         kind_r     <= K_PERI;
         idx_r      <= 6'h00;
         num_r      <= 8'h00;
         newlvl_r   <= LVL_OFF;
         ipl_load_r <= 1'b0;
         len_r      <= LEN_BASE;
         byte_r     <= 1'b0;
      end
      else if (accept)
      begin
         kind_r     <= kind_sel;
         idx_r      <= best_idx;
         num_r      <= num_sel;
         // nmi/watchdog to 7, others
         newlvl_r   <= (kind_sel == K_PERI) ? best_lvl : LVL_TOP;
         ipl_load_r <= (kind_sel == K_PERI) | (kind_sel == K_NMI) | (kind_sel == K_WDT);
         len_r      <= len_sel;
         byte_r     <= sp_odd;
      end
   end

   // flag word, temporary copy and push words
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         flag_r     <= FLG_RESET; // ipl 0, enable 0
         flag_tmp_r <= FLG_RESET;
         w1_r       <= 16'h0000;
         pcl_r      <= 16'h0000;
      end
      else if (state_r == S_INFO)
      begin
         flag_tmp_r <= flag_r;
         w1_r       <= {core_pc[19:16], flag_r[15:12], flag_r[7:0]};
         pcl_r      <= core_pc[15:0];
         flag_r[FLG_I_BIT] <= 1'b0;
         flag_r[FLG_D_BIT] <= 1'b0;
         if (!keep_u)
            flag_r[FLG_U_BIT] <= 1'b0;
      end
      else if (state_r == S_LOAD)
      begin
         if (ipl_load_r)
            flag_r[FLG_IPL_LO +: LVL_W] <= newlvl_r;
      end
      else if (wr_acc && hit_flag)
         flag_r <= pwdata[15:0];
   end

   // entry side outputs
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         start_r    <= 1'b0;
         stk_wr_r   <= 1'b0;
         stk_data_r <= 16'h0000;
         info_num_r <= 8'h00;
         info_lvl_r <= LVL_OFF;
      end
      else
      begin
         start_r  <= accept;
         stk_wr_r <= (state_r == S_PUSH);
         if (state_r == S_PUSH)
            stk_data_r <= push_data;
         if (accept)
         begin
            info_num_r <= num_sel;
            info_lvl_r <= (kind_sel == K_PERI) ? best_lvl : LVL_OFF;
         end
      end
   end

   // apb read data and error, set up in the setup cycle
   assign rd_mux = hit_flag ? {16'h0000, flag_r} :
                   hit_stat ? {27'h0000000, kind_r, any_req, entry_busy} :
                   hit_info ? {21'h000000, info_lvl_r, info_num_r} :
                   src_rd_data;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         prdata_r  <= 32'h0000_0000;
         pslverr_r <= 1'b0;
      end
      else if (rd_setup)
      begin
         prdata_r  <= pwrite ? 32'h0000_0000 : rd_mux;
         pslverr_r <= ~(hit_flag | hit_stat | hit_info | hit_src);
      end
   end

   assign prdata       = prdata_r;
   assign pslverr      = pslverr_r & psel & penable;
   assign pready       = 1'b1;
   assign core_suspend = accept & core_suspendable & ~core_instr_done;
   assign entry_start  = start_r;
   assign entry_kind   = kind_r;
   assign entry_busy   = (state_r != S_IDLE);
   assign info_rd      = (state_r == S_INFO);
   assign info_num     = info_num_r;
   assign info_lvl     = info_lvl_r;
   assign stk_wr       = stk_wr_r;
   assign stk_byte     = byte_r;
   assign stk_data     = stk_data_r;
   assign entry_done   = (state_r == S_LOAD);
   assign flag_word    = flag_r;
endmodule
`default_nettype wire

// *** bench/mip_core_model.sv ***
// processor core stand-in: instruction boundaries, pc and held special requests
`timescale 1ns/1ps
`default_nettype none
module mip_core_model
   import mip_pkg::*;
(
   input  wire logic                  pclk,
   input  wire logic                  presetn,
   input  wire logic [4:0]            ilen,
   input  wire logic [6:0]            raise,
   input  wire logic                  entry_start,
   input  wire mip_pkg::mip_kind_t    entry_kind,
   input  wire logic                  entry_busy,
   output var  logic                  core_instr_done,
   output var  logic [mip_pkg::PC_W-1:0] core_pc,
   output var  logic [6:0]            req
);
   logic [4:0] cnt_r;
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
      begin
         cnt_r <= 5'h0;
         core_instr_done <= 1'b0;
         core_pc <= 20'h0;
         req <= 7'h0;
      end
      else
      begin
         // boundary every ilen cycles, none during entry
         core_instr_done <= !entry_busy && cnt_r >= ilen;
         cnt_r <= (entry_busy || cnt_r >= ilen) ? 5'h1 : cnt_r + 5'h1;
         if (core_instr_done)
            core_pc <= core_pc + 20'h3;
         // special request held until its entry starts
         req <= (req | raise) & ~(7'(entry_start) << entry_kind);
      end
endmodule
`default_nettype wire

// *** bench/mip_chk.sv ***
// concurrent checks on the sequencer ports
`timescale 1ns/1ps
`default_nettype none
module mip_chk
   import mip_pkg::*;
(
   input wire logic                   pclk,
   input wire logic                   presetn,
   input wire logic                   psel,
   input wire logic                   penable,
   input wire logic [mip_pkg::ADDR_W-1:0] paddr,
   input wire logic                   pslverr,
   input wire logic                   sp_odd,
   input wire logic                   vec_odd,
   input wire logic                   bus8,
   input wire logic [mip_pkg::PC_W-1:0] core_pc,
   input wire logic                   entry_start,
   input wire mip_pkg::mip_kind_t     entry_kind,
   input wire logic                   entry_busy,
   input wire logic                   info_rd,
   input wire logic [mip_pkg::LVL_W-1:0] info_lvl,
   input wire logic                   stk_wr,
   input wire logic                   stk_byte,
   input wire logic [15:0]            stk_data,
   input wire logic                   entry_done,
   input wire logic [15:0]            flag_word
);
   logic [4:0]  cnt_r, len_r, add;
   logic        sp_r, vo_r, b8_r;
   logic [19:0] pc_r;
   logic [15:0] fl_r;
   assign add = entry_kind == K_DBG ? LEN_DBG_ADD : (entry_kind == K_STEP || entry_kind == K_AM) ? LEN_ONE_ADD : 5'h0;
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
      begin
         {cnt_r, len_r, sp_r, vo_r, b8_r, pc_r, fl_r} <= '0;
      end
      else
      begin
         {sp_r, vo_r, b8_r} <= {sp_odd, vec_odd, bus8};
         if (entry_start)
         begin
            cnt_r <= 5'h2;
            len_r <= (b8_r ? LEN_BUS8 : LEN_BASE + 5'(vo_r) + 5'(sp_r)) + add;
            pc_r <= core_pc;
            fl_r <= flag_word;
         end
         else if (entry_busy)
            cnt_r <= cnt_r + 5'h1;
      end
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence word_push;
      ##2 stk_wr && stk_data == {pc_r[19:16], fl_r[15:12], fl_r[7:0]} ##1 stk_wr && stk_data == pc_r[15:0];
   endsequence
   sequence byte_push;
      ##2 stk_wr && stk_byte && stk_data[7:0] == fl_r[7:0] ##1 stk_wr && stk_data[7:0] == {pc_r[19:16], fl_r[15:12]}
      ##1 stk_wr && stk_data[7:0] == pc_r[7:0] ##1 stk_wr && stk_data[7:0] == pc_r[15:8];
   endsequence
   rst_clear_a: assert property ($rose(presetn) |-> flag_word == FLG_RESET)
      else $error("flag word not clear after reset");
   gate_enable_a: assert property (entry_start && entry_kind == K_PERI |-> $past(flag_word[FLG_I_BIT]))
      else $error("maskable entry with enable low");
   lvl_above_a: assert property (entry_start && entry_kind == K_PERI |-> info_lvl > $past(flag_word[14:12]))
      else $error("accepted level not above ipl");
   info_first_a: assert property (entry_start |-> info_rd && entry_busy)
      else $error("entry did not open with info read");
   flags_clear_a: assert property (entry_start |=> !flag_word[FLG_I_BIT] && !flag_word[FLG_D_BIT]
      && (entry_kind == K_SWI || !flag_word[FLG_U_BIT]))
      else $error("flags not cleared on entry");
   entry_len_a: assert property (entry_done |-> cnt_r == len_r)
      else $error("entry length wrong");
   push_word_a: assert property (entry_start && !sp_r |-> word_push)
      else $error("word push wrong");
   push_byte_a: assert property (entry_start && sp_r |-> byte_push)
      else $error("byte push wrong");
   ipl_load_a: assert property (entry_done && entry_kind == K_PERI |=> flag_word[14:12] == info_lvl)
      else $error("ipl not loaded with accepted level");
   ipl_fixed_a: assert property (entry_done && (entry_kind == K_NMI || entry_kind == K_WDT)
      |=> flag_word[14:12] == LVL_TOP)
      else $error("ipl not raised to top");
   done_gap_a: assert property (entry_done |=> !entry_busy && !entry_start)
      else $error("entry overlapped previous one");
   unmapped_a: assert property (psel && penable && paddr > 12'h008 && paddr < 12'h100 |-> pslverr)
      else $error("unmapped access not refused");
endmodule
bind mip_sequencer mip_chk u_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .paddr(paddr),
   .pslverr(pslverr), .sp_odd(sp_odd), .vec_odd(vec_odd), .bus8(bus8), .core_pc(core_pc),
   .entry_start(entry_start), .entry_kind(entry_kind), .entry_busy(entry_busy), .info_rd(info_rd),
   .info_lvl(info_lvl), .stk_wr(stk_wr), .stk_byte(stk_byte), .stk_data(stk_data), .entry_done(entry_done),
   .flag_word(flag_word));
`default_nettype wire

// *** bench/mip_sequencer_test.sv ***
// self-checking bench for the interrupt sequencer
`timescale 1ns/1ps
`default_nettype none
module mip_sequencer_test;
   import mip_pkg::*;
   logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h0, sa;
   logic [31:0] pwdata = 32'h0, prdata;
   logic [27:0] src_req = '0;
   logic        core_suspendable = 1'b0, sp_odd = 1'b0, vec_odd = 1'b0, bus8 = 1'b0, saw_susp = 1'b0;
   logic [6:0]  raise = '0, req;
   logic [4:0]  ilen = 5'h3;
   logic        pready, pslverr, core_instr_done, core_suspend, entry_start, entry_busy, info_rd;
   logic        stk_wr, stk_byte, entry_done;
   logic [7:0]  info_num;
   logic [2:0]  info_lvl;
   logic [15:0] stk_data, flag_word;
   logic [19:0] core_pc;
   mip_kind_t   entry_kind;
   logic [32:0] apb_q[$];
   logic [13:0] ent_q[$];
   logic [7:0]  nums [1:6] = '{NUM_NMI, NUM_DBG, NUM_WDT, NUM_STEP, NUM_AMATCH, 8'h25};
   int          fails = 0, comparisons = 0, cycles = 0, seed = 32'h18b9, k, idx, processor_priority_level, lv;
   mip_sequencer dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .src_req(src_req),
      .core_instr_done(core_instr_done), .core_suspendable(core_suspendable), .nmi_req(req[1]), .dbg_req(req[2]),
      .wdt_req(req[3]), .step_req(req[4]), .amatch_req(req[5]), .swi_req(req[6]), .swi_num(8'h25),
      .core_pc(core_pc), .sp_odd(sp_odd), .vec_odd(vec_odd), .bus8(bus8), .core_suspend(core_suspend),
      .entry_start(entry_start), .entry_kind(entry_kind), .entry_busy(entry_busy), .info_rd(info_rd),
      .info_num(info_num), .info_lvl(info_lvl), .stk_wr(stk_wr), .stk_byte(stk_byte), .stk_data(stk_data),
      .entry_done(entry_done), .flag_word(flag_word));
   mip_core_model core (.pclk(pclk), .presetn(presetn), .ilen(ilen), .raise(raise), .entry_start(entry_start),
      .entry_kind(entry_kind), .entry_busy(entry_busy), .core_instr_done(core_instr_done), .core_pc(core_pc),
      .req(req));
   always #10 pclk = ~pclk;
   task automatic check(input logic [63:0] seen, input logic [63:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         fails++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic end_sim;
      $display("fails=%0d comparisons=%0d", fails, comparisons);
      if (fails == 0 && comparisons > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [32:0] e);
      apb_q.push_back(e);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1)
         @(posedge pclk);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d, 33'h0);
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0, {1'b0, e});
   endtask
   task automatic pulse(input logic [27:0] m);
      @(posedge pclk);
      src_req <= m;
      @(posedge pclk);
      src_req <= '0;
   endtask
   task automatic settle;
      int n;
      n = 0;
      do
      begin
         @(posedge pclk);
         n++;
      end
      while (entry_done !== 1'b1 && n < 60);
      check(n < 60, 1'b1);
   endtask
   always @(posedge pclk)
      if (psel && penable && pready)
         check({pslverr, prdata}, apb_q.pop_front());
   always @(posedge pclk)
   begin
      if (entry_start === 1'b1)
         check({entry_kind, info_num, info_lvl}, ent_q.pop_front());
      if (core_suspend === 1'b1)
         saw_susp <= 1'b1;
      cycles++;
      if (cycles == 20000)
      begin
         fails++;
         end_sim();
      end
   end
   initial
   begin
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      rd(ADDR_FLAG, 32'h0);
      rd(12'h100, 32'h0);
      apb(1'b0, 12'h00c, 32'h0, {1'b1, 32'h0});
      wr(12'h108, 32'h5);
      pulse(28'h4);
      rd(12'h108, 32'hd);
      wr(12'h108, 32'hd);
      rd(12'h108, 32'hd);
      wr(12'h108, 32'h5);
      wr(12'h108, 32'hd);
      rd(12'h108, 32'h5);
      $display("test registers done");
      for (k = 0; k < 6; k++)
      begin
         idx = $unsigned($random(seed)) % 28;
         processor_priority_level = $unsigned($random(seed)) % 7;
         lv = processor_priority_level + 1 + $unsigned($random(seed)) % (7 - processor_priority_level);
         {sp_odd, vec_odd, bus8} <= 3'($random(seed));
         ilen <= 5'(1 + $unsigned($random(seed)) % 30);
         sa = 12'(32'h100 + 4 * idx);
         wr(ADDR_FLAG, 32'(processor_priority_level << 12));
         wr(sa, 32'(processor_priority_level));
         wr(ADDR_FLAG, 32'(processor_priority_level << 12) | 32'h40);
         pulse(28'(1) << idx);
         repeat (40) @(posedge pclk);
         ent_q.push_back({K_PERI, 8'(SRC_NUM_BASE + idx), 3'(lv)});
         wr(sa, 32'(lv) | 32'h8);
         settle;
         rd(ADDR_FLAG, 32'(lv << 12));
         rd(sa, 32'(lv));
      end
      $display("test acceptance done");
      ilen <= 5'h3;
      wr(ADDR_FLAG, 32'h0);
      wr(12'h118, 32'h5);
      wr(12'h124, 32'h5);
      pulse(28'h240);
      ent_q.push_back({K_PERI, 8'h0a, 3'h5});
      ent_q.push_back({K_PERI, 8'h0d, 3'h5});
      wr(ADDR_FLAG, 32'h40);
      settle;
      wr(ADDR_FLAG, 32'h40);
      settle;
      $display("test tie done");
      wr(12'h10c, 32'h7);
      wr(ADDR_FLAG, 32'h7040);
      pulse(28'h8);
      repeat (40) @(posedge pclk);
      wr(ADDR_FLAG, 32'h0);
      repeat (40) @(posedge pclk);
      core_suspendable <= 1'b1;
      ilen <= 5'h1f;
      ent_q.push_back({K_PERI, 8'h07, 3'h7});
      wr(ADDR_FLAG, 32'h40);
      settle;
      check(saw_susp, 1'b1);
      core_suspendable <= 1'b0;
      ilen <= 5'h3;
      $display("test block and suspend done");
      for (k = 1; k < 7; k++)
      begin
         wr(ADDR_FLAG, 32'h20a0);
         {sp_odd, vec_odd, bus8} <= 3'($random(seed));
         ent_q.push_back({3'(k), nums[k], 3'h0});
         @(posedge pclk);
         raise <= 7'(1 << k);
         @(posedge pclk);
         raise <= '0;
         settle;
         rd(ADDR_FLAG, ((k == 1 || k == 3) ? 32'h7000 : 32'h2000) | (k == 6 ? 32'h80 : 32'h0));
      end
      rd(ADDR_STATUS, 32'h18);
      $display("test special entries done");
      end_sim();
   end
endmodule
`default_nettype wire
